// *** bench/pma_board.sv ***
// board-side model: device clock pin and undriven macrocell pins
`timescale 1ns/10ps
module pma_board (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic por_busy_i,
   input wire logic pulse_i,
   output logic clk_pin_o,
   output logic [7:0] pin_o,
   output logic [7:0] pin_drv_o
);
   logic [1:0] quiet;
   // ==========================================================
   // clock pin
   // still in reset, setup first
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i || por_busy_i)
      begin
         quiet <= 2'h0;
         clk_pin_o <= 1'h0;
      end
      else
      begin
         if (quiet != 2'h3)
            quiet <= quiet + 2'h1;
         clk_pin_o <= pulse_i & (quiet == 2'h3);
      end
   end
   // ==========================================================
   // pins nobody drives sit at the pull-up level
   assign pin_drv_o = 8'h00;
   assign pin_o = 8'hFF;
endmodule // pma_board

// *** bench/tb.sv ***
// self-checking bench for the macrocell array
`timescale 1ns/10ps
module tb;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic clk_pin, secure, por_busy;
   logic oe_n = 1'h0, oe_drv = 1'h1, pulse = 1'h0, wr = 1'h0, rd = 1'h0;
   logic pre = 1'h0, sig_wr = 1'h0, fuse = 1'h0, erase = 1'h0;
   logic [7:0] in_v = 8'h00, in_drv = 8'hFF, pre_d = 8'h00, pin_ext, pin_drv, pin, pin_oe_n;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [63:0] sig_d = 64'h0, sig;
   logic [31:0] pat [64];
   pma_pkg::pma_cells_t cfg;
   pma_pkg::pma_mode_e mode;
   int num_errors = 0;
   int num_checks = 0;
   int n;
   localparam logic [7:0] R_IN [4] = '{8'h00, 8'hFF, 8'hA5, 8'h00};
   localparam logic [7:0] R_DRV [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
   localparam logic R_OEN [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
   localparam logic [7:0] R_PIN [4] = '{8'hFF, 8'h00, 8'h5A, 8'h0F};
   localparam logic [7:0] R_OE [4] = '{8'h00, 8'h00, 8'hFF, 8'h00};
   localparam int POR_CYC = pma_pkg::POWER_UP_RESET_TIME_NS / pma_pkg::CLK_PERIOD_NS;
   always #10 mclk = ~mclk;
   pma_top dut_u (.mclk_i(mclk), .rst_i(rst), .clk_pin_i(clk_pin), .oe_n_pin_i(oe_n),
      .oe_drv_i(oe_drv), .in_i(in_v), .in_drv_i(in_drv), .pin_i(pin_ext), .pin_drv_i(pin_drv),
      .pin_o(pin), .pin_oe_n_o(pin_oe_n), .cell_cfg_i(cfg), .mode_o(mode), .cfg_wr_i(wr),
      .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_data_i(wdata), .cfg_rd_data_o(rdata),
      .preload_en_i(pre), .preload_data_i(pre_d), .sig_wr_i(sig_wr), .sig_data_i(sig_d),
      .sig_o(sig), .fuse_prog_i(fuse), .erase_i(erase), .secure_o(secure), .por_busy_o(por_busy));
   pma_board board_u (.mclk_i(mclk), .rst_i(rst), .por_busy_i(por_busy), .pulse_i(pulse),
      .clk_pin_o(clk_pin), .pin_o(pin_ext), .pin_drv_o(pin_drv));
   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic tick;
      @(posedge mclk) pulse <= 1'h1;
      @(posedge mclk) pulse <= 1'h0;
      step(3);
   endtask
   task automatic drive(input logic [7:0] v, input logic [7:0] d, input logic o);
      @(posedge mclk);
      in_v <= v;
      in_drv <= d;
      oe_n <= o;
      step(2);
   endtask
   task automatic set_all(input pma_pkg::pma_cell_e k);
      @(posedge mclk);
      for (int i = 0; i < pma_pkg::N_CELL; i++)
         cfg[i] <= k;
      step(2);
   endtask
   task automatic read(input logic [5:0] a);
      @(posedge mclk);
      rd <= 1'h1;
      addr <= a;
      @(posedge mclk) rd <= 1'h0;
      step(1);
   endtask
   task automatic wait_por;
      n = 0;
      while (por_busy !== 1'h0 && n < 200)
      begin
         step(1);
         n++;
      end
      if (por_busy !== 1'h0)
      begin
         num_errors++;
         end_sim;
      end
   endtask
   // ==========================================================
   // watchdog: a hang ends in the closing report
   initial
   begin
      #400000;
      num_errors++;
      end_sim;
   end
   // ==========================================================
   // main sequence
   initial
   begin
      for (int i = 0; i < pma_pkg::N_CELL; i++)
         cfg[i] = pma_pkg::CELL_REG;
      // cell c keeps term c on its own input literal, all other terms stay false
      for (int a = 0; a < 64; a++)
         pat[a] = (a % 9 == 0) ? (32'h1 << (2 * (a / 9))) : 32'hFFFF_FFFF;
      repeat (12) @(posedge mclk);
      rst <= 1'h0;
      wait_por;
      chk("por_cycles", 64'(n), 64'(POR_CYC));
      chk("pin_after_por", 64'(pin), 64'hFF);
      $display("test power_up done");
      for (int a = 0; a < 64; a++)
      begin
         @(posedge mclk);
         wr <= 1'h1;
         addr <= 6'(a);
         wdata <= pat[a];
      end
      @(posedge mclk) wr <= 1'h0;
      for (int r = 0; r < 4; r++)
      begin
         drive(R_IN[r], R_DRV[r], R_OEN[r]);
         tick;
         chk("reg_pin", 64'(pin), 64'(R_PIN[r]));
         chk("reg_oe", 64'(pin_oe_n), 64'(R_OE[r]));
      end
      // new inputs without a clock-pin rise must not reach the registers
      drive(8'hFF, 8'hFF, 1'h0);
      chk("no_tick", 64'(pin), 64'h0F);
      @(posedge mclk) oe_drv <= 1'h0;
      step(2);
      chk("oe_pulled_up", 64'(pin_oe_n), 64'hFF);
      @(posedge mclk) oe_drv <= 1'h1;
      $display("test registered done");
      @(posedge mclk);
      pre <= 1'h1;
      pre_d <= 8'h5A;
      @(posedge mclk) pre <= 1'h0;
      step(2);
      chk("preload", 64'(pin), 64'hA5);
      @(posedge mclk);
      cfg[0] <= pma_pkg::CELL_COM_IO;
      cfg[1] <= pma_pkg::CELL_INPUT;
      drive(8'h01, 8'hFF, 1'h0);
      chk("mode_mixed", 64'(mode), 64'(pma_pkg::MODE_REGISTERED));
      chk("com_oe_on", 64'(pin_oe_n[1:0]), 64'h2);
      chk("com_sum7", 64'(pin[0]), 64'h0);
      drive(8'h00, 8'hFF, 1'h0);
      chk("com_oe_off", 64'(pin_oe_n[0]), 64'h1);
      set_all(pma_pkg::CELL_COM_IO);
      chk("mode_complex", 64'(mode), 64'(pma_pkg::MODE_COMPLEX));
      set_all(pma_pkg::CELL_COM_OUT);
      drive(8'hA5, 8'hFF, 1'h1);
      chk("mode_simple", 64'(mode), 64'(pma_pkg::MODE_SIMPLE));
      chk("simple_pin", 64'({pin, pin_oe_n}), 64'hA500);
      set_all(pma_pkg::CELL_INPUT);
      chk("input_oe", 64'(pin_oe_n), 64'hFF);
      set_all(pma_pkg::CELL_REG);
      chk("mode_reg", 64'(mode), 64'(pma_pkg::MODE_REGISTERED));
      $display("test modes done");
      drive(8'h3C, 8'hFF, 1'h0);
      tick;
      read(6'h09);
      chk("readback", 64'(rdata), 64'(pat[9]));
      @(posedge mclk);
      sig_wr <= 1'h1;
      sig_d <= 64'h0123_4567_89AB_CDEF;
      @(posedge mclk);
      sig_wr <= 1'h0;
      fuse <= 1'h1;
      @(posedge mclk) fuse <= 1'h0;
      step(1);
      chk("secure", 64'(secure), 64'h1);
      read(6'h09);
      chk("readback_blocked", 64'(rdata), 64'h0);
      @(posedge mclk);
      pre <= 1'h1;
      pre_d <= 8'h00;
      @(posedge mclk) pre <= 1'h0;
      step(2);
      chk("preload_blocked", 64'(pin), 64'hC3);
      chk("sig_secured", sig, 64'h0123_4567_89AB_CDEF);
      // a secured pattern refuses writes; fuse and erase together leave it secured
      @(posedge mclk);
      wr <= 1'h1;
      addr <= 6'h09;
      wdata <= 32'h0000_0000;
      @(posedge mclk);
      wr <= 1'h0;
      erase <= 1'h1;
      fuse <= 1'h1;
      @(posedge mclk);
      erase <= 1'h0;
      fuse <= 1'h0;
      step(1);
      chk("fuse_beats_erase", 64'(secure), 64'h1);
      @(posedge mclk) erase <= 1'h1;
      @(posedge mclk) erase <= 1'h0;
      step(1);
      chk("erased", 64'(secure), 64'h0);
      read(6'h09);
      chk("write_refused", 64'(rdata), 64'(pat[9]));
      $display("test security done");
      @(posedge mclk) rst <= 1'h1;
      @(posedge mclk) rst <= 1'h0;
      wait_por;
      chk("pin_second_por", 64'(pin), 64'hFF);
      $display("test second_reset done");
      end_sim;
   end
endmodule // tb

// *** hdl/pma_pkg.sv ***
// constants, enumerations and state layout for the macrocell array
package pma_pkg;
   // ==========================================================
   // geometry
   localparam int N_CELL = 8;
   localparam int N_IN = 8;
   localparam int N_TERM = 8;
   localparam int N_ARR = N_IN + N_CELL;
   localparam int LIT_W = 2 * N_ARR;
   localparam int ADDR_W = 6;
   localparam int SIG_W = 64;
   localparam int RD_W = LIT_W;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int POWER_UP_RESET_TIME_NS = 1000;
   localparam int POR_CYC_INT = (POWER_UP_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CNT_W = 6;
   localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC_INT - 1);
   // ==========================================================
   // reset values
   localparam logic [N_CELL-1:0] REGS_RST = 8'h00;
   localparam logic [N_CELL-1:0] PIN_O_RST = 8'h00;
   localparam logic [N_CELL-1:0] PIN_OE_N_RST = 8'hFF;
   localparam logic [POR_CNT_W-1:0] POR_CNT_RST = 6'h00;
   localparam logic [SIG_W-1:0] SIG_RST = 64'h0000_0000_0000_0000;
   localparam logic [RD_W-1:0] RD_RST = 32'h0000_0000;
   // ==========================================================
   // per-cell and global modes
   typedef enum logic [1:0] {CELL_REG, CELL_COM_IO, CELL_COM_OUT, CELL_INPUT} pma_cell_e;
   typedef pma_cell_e [N_CELL-1:0] pma_cells_t;
   typedef enum logic [1:0] {MODE_REGISTERED, MODE_COMPLEX, MODE_SIMPLE} pma_mode_e;
   // ==========================================================
   // whole state of the top module
   typedef struct packed {
      logic [N_CELL-1:0] regs;
      logic [N_CELL-1:0] pin_o;
      logic [N_CELL-1:0] pin_oe_n;
      logic clk_prev;
      logic por_busy;
      logic [POR_CNT_W-1:0] por_cnt;
      logic secure;
      logic [SIG_W-1:0] sig;
      logic [RD_W-1:0] rd_data;
   } pma_state_s;
endpackage

// *** hdl/pma_top.sv ***
// eight-macrocell programmable logic array with power-up reset, preload, signature, fuse
//
// Behaviour
// - after power-up every macrocell register clears, registered pins read high
// - preload can force each register to one or zero
// - 64-bit user signature stays readable at all times, even when secured
// - programmed security fuse at once blocks pattern readback and preload
// - eight macrocells, each registered, combinatorial I/O, combinatorial output or input
// - exactly one global mode: registered, complex or simple
// - registered mode whenever any macrocell uses its register
// - registered outputs enabled by shared low-active enable pin, clocked by clock pin
// - a registered cell sums eight product terms into its register input
// - combinatorial cell in registered mode: one term enables, seven are summed
// - a dedicated input cell never drives its pin
`timescale 1ns/10ps
module pma_top #(
   parameter int N_CELL = pma_pkg::N_CELL,
   parameter int N_IN = pma_pkg::N_IN
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clk_pin_i,
   input wire logic oe_n_pin_i,
   input wire logic oe_drv_i,
   input wire logic [N_IN-1:0] in_i,
   input wire logic [N_IN-1:0] in_drv_i,
   input wire logic [N_CELL-1:0] pin_i,
   input wire logic [N_CELL-1:0] pin_drv_i,
   output logic [N_CELL-1:0] pin_o,
   output logic [N_CELL-1:0] pin_oe_n_o,
   input wire pma_pkg::pma_cells_t cell_cfg_i,
   output pma_pkg::pma_mode_e mode_o,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [pma_pkg::ADDR_W-1:0] cfg_addr_i,
   input wire logic [pma_pkg::LIT_W-1:0] cfg_data_i,
   output logic [pma_pkg::RD_W-1:0] cfg_rd_data_o,
   input wire logic preload_en_i,
   input wire logic [N_CELL-1:0] preload_data_i,
   input wire logic sig_wr_i,
   input wire logic [pma_pkg::SIG_W-1:0] sig_data_i,
   output logic [pma_pkg::SIG_W-1:0] sig_o,
   input wire logic fuse_prog_i,
   input wire logic erase_i,
   output logic secure_o,
   output logic por_busy_o
);
   // ==========================================================
   // state and pattern memory
   pma_pkg::pma_state_s s;
   pma_pkg::pma_state_s next_s;
   // pattern words are not reset: they stand for non-volatile cells
   logic [pma_pkg::LIT_W-1:0] pattern [N_CELL*pma_pkg::N_TERM];
   wire logic [pma_pkg::N_ARR-1:0] array_in;
   wire logic [pma_pkg::N_TERM-1:0] pt [N_CELL];
   wire logic [N_CELL-1:0] sum_all;
   wire logic [N_CELL-1:0] sum_seven;
   wire logic [N_CELL-1:0] reg_mask;
   wire logic [N_CELL-1:0] io_mask;
   wire logic [N_CELL-1:0] in_mask;
   logic clk_rise;
   logic oe_pin_low;
   pma_pkg::pma_mode_e mode;

   // connected literal: bit 2k needs x[k] high, bit 2k+1 needs x[k] low
   function automatic logic pma_term(input logic [pma_pkg::LIT_W-1:0] m,
                                     input logic [pma_pkg::N_ARR-1:0] x);
      logic r;
      r = 1'b1;
      for (int k = 0; k < pma_pkg::N_ARR; k++)
      begin
         r = r & (~m[2*k] | x[k]) & (~m[2*k+1] | ~x[k]);
      end
      return r;
   endfunction

   // ==========================================================
   // array inputs and product terms
   // undriven pins pull high
   assign oe_pin_low = oe_drv_i & ~oe_n_pin_i;
   assign clk_rise = clk_pin_i & ~s.clk_prev;

   genvar gi;
   generate
      for (gi = 0; gi < N_CELL; gi++)
      begin : g_cell
         assign reg_mask[gi] = (cell_cfg_i[gi] == pma_pkg::CELL_REG);
         assign io_mask[gi] = (cell_cfg_i[gi] == pma_pkg::CELL_COM_IO);
         assign in_mask[gi] = (cell_cfg_i[gi] == pma_pkg::CELL_INPUT);
         assign array_in[gi] = in_drv_i[gi] ? in_i[gi] : 1'b1;
         // registers feed back internally, other cells through their pin
         assign array_in[N_IN+gi] = reg_mask[gi] ? s.regs[gi] :
                                    (~s.pin_oe_n[gi] ? s.pin_o[gi] :
                                    (pin_drv_i[gi] ? pin_i[gi] : 1'b1));
         for (genvar t = 0; t < pma_pkg::N_TERM; t++)
         begin : g_term
            assign pt[gi][t] = pma_term(pattern[gi*pma_pkg::N_TERM+t], array_in);
         end
         assign sum_all[gi] = |pt[gi];
         assign sum_seven[gi] = |pt[gi][pma_pkg::N_TERM-1:1];
      end
   endgenerate

   // ==========================================================
   // global mode
   // mode from usage
   always_comb
   begin
      if (|reg_mask)
         mode = pma_pkg::MODE_REGISTERED;
      else if (|io_mask)
         mode = pma_pkg::MODE_COMPLEX;
      else
         mode = pma_pkg::MODE_SIMPLE;
   end

   // ==========================================================
   // next state
   always_comb
   begin
      next_s = s;
      next_s.clk_prev = clk_pin_i;
      if (s.por_busy)
      begin
         next_s.regs = pma_pkg::REGS_RST;
         if (s.por_cnt == pma_pkg::POR_LAST)
            next_s.por_busy = 1'b0;
         else
            next_s.por_cnt = s.por_cnt + 1'b1;
      end
      else if (preload_en_i && !s.secure)
         next_s.regs = preload_data_i;
      else if (clk_rise)
      begin
         for (int i = 0; i < N_CELL; i++)
         begin
            if (reg_mask[i])
               next_s.regs[i] = sum_all[i];
         end
      end
      for (int i = 0; i < N_CELL; i++)
      begin
         case (cell_cfg_i[i])
            pma_pkg::CELL_REG:
            begin
               next_s.pin_o[i] = ~next_s.regs[i];
               next_s.pin_oe_n[i] = ~oe_pin_low;
            end
            pma_pkg::CELL_COM_IO, pma_pkg::CELL_COM_OUT:
            begin
               if (mode == pma_pkg::MODE_SIMPLE)
               begin
                  next_s.pin_o[i] = sum_all[i];
                  next_s.pin_oe_n[i] = 1'b0;
               end
               else
               begin
                  next_s.pin_o[i] = sum_seven[i];
                  next_s.pin_oe_n[i] = ~pt[i][0];
               end
            end
            default:
            begin
               next_s.pin_o[i] = 1'b0;
               next_s.pin_oe_n[i] = 1'b1;
            end
         endcase
      end
      if (erase_i)
         next_s.secure = 1'b0;
      // fuse acts at once; programming it after erase wins
      if (fuse_prog_i)
         next_s.secure = 1'b1;
      // signature never gated by the fuse
      if (sig_wr_i)
         next_s.sig = sig_data_i;
      if (cfg_rd_i)
         next_s.rd_data = s.secure ? pma_pkg::RD_RST : pattern[cfg_addr_i];
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s.regs <= pma_pkg::REGS_RST;
         s.pin_o <= pma_pkg::PIN_O_RST;
         s.pin_oe_n <= pma_pkg::PIN_OE_N_RST;
         s.clk_prev <= 1'b0;
         s.por_busy <= 1'b1;
         s.por_cnt <= pma_pkg::POR_CNT_RST;
         s.secure <= 1'b0;
         s.sig <= pma_pkg::SIG_RST;
         s.rd_data <= pma_pkg::RD_RST;
      end
      else
         s <= next_s;
   end

   // writes to a secured pattern are refused until erase or reset
   always_ff @(posedge mclk_i)
   begin
      if (cfg_wr_i && !s.secure)
         pattern[cfg_addr_i] <= cfg_data_i;
   end

   assign pin_o = s.pin_o;
   assign pin_oe_n_o = s.pin_oe_n;
   assign mode_o = mode;
   assign cfg_rd_data_o = s.rd_data;
   assign sig_o = s.sig;
   assign secure_o = s.secure;
   assign por_busy_o = s.por_busy;

   // ==========================================================
   // checks
   property p_por_clear;
      @(posedge mclk_i) disable iff (rst_i)
      s.por_busy |=> (s.regs == 8'h00) && ((pin_o | ~$past(reg_mask)) == 8'hFF);
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-up clear lost");

   property p_preload;
      @(posedge mclk_i) disable iff (rst_i)
      (!s.por_busy && preload_en_i && !s.secure) |=> s.regs == $past(preload_data_i);
   endproperty
   a_preload: assert property (p_preload) else $error("preload not taken");

   property p_preload_block;
      @(posedge mclk_i) disable iff (rst_i)
      (!s.por_busy && preload_en_i && s.secure && !clk_rise) |=> $stable(s.regs);
   endproperty
   a_preload_block: assert property (p_preload_block) else $error("secured preload");

   property p_read_block;
      @(posedge mclk_i) disable iff (rst_i)
      (cfg_rd_i && s.secure) |=> cfg_rd_data_o == 32'h0000_0000;
   endproperty
   a_read_block: assert property (p_read_block) else $error("secured readback");

   property p_sig;
      @(posedge mclk_i) disable iff (rst_i)
      sig_wr_i |=> sig_o == $past(sig_data_i) ##1 ($past(sig_wr_i) || $stable(sig_o));
   endproperty
   a_sig: assert property (p_sig) else $error("signature not kept");

   property p_input_off;
      @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> ((~pin_oe_n_o) & $past(in_mask)) == 8'h00;
   endproperty
   a_input_off: assert property (p_input_off) else $error("input cell drives");

   property p_reg_oe;
      @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> ((pin_oe_n_o ^ {N_CELL{~$past(oe_pin_low)}}) & $past(reg_mask)) == 8'h00;
   endproperty
   a_reg_oe: assert property (p_reg_oe) else $error("register enable wrong");

   property p_com_oe;
      @(posedge mclk_i) disable iff (rst_i)
      (mode == pma_pkg::MODE_REGISTERED && !reg_mask[0] && !in_mask[0])
         |=> pin_oe_n_o[0] == !$past(pt[0][0]) && pin_o[0] == $past(sum_seven[0]);
   endproperty
   a_com_oe: assert property (p_com_oe) else $error("term enable wrong");

   property p_capture;
      @(posedge mclk_i) disable iff (rst_i)
      (!s.por_busy && !preload_en_i && clk_rise && reg_mask[0])
         |=> s.regs[0] == $past(sum_all[0]) && (pin_o[0] == ~s.regs[0]);
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");

   property p_mode;
      @(posedge mclk_i) disable iff (rst_i)
      (|reg_mask) |-> mode_o == pma_pkg::MODE_REGISTERED;
   endproperty
   a_mode: assert property (p_mode) else $error("mode not registered");
endmodule // pma_top
